// ---- spi_port_pkg.sv ----
// Purpose: shared constants and types of the analog die serial register port
// Assumes: 10 MHz ref_clk, serial clock well below a quarter of it
// Notes: register offsets are the printed ones
package spi_port_pkg;
    localparam int unsigned REG_COUNT = 18;
    localparam int unsigned IMAGE_W = REG_COUNT * 8;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] CNT_OVER = 5'h11;
    localparam logic [4:0] PARITY_SAMPLE = 5'h06;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [4:0] OFS_SYSTEM_CONTROL = 5'h00;
    localparam logic [4:0] OFS_HALF_BRIDGE_OUTPUT = 5'h01;
    localparam logic [4:0] OFS_HIGH_SIDE_OUTPUT = 5'h02;
    localparam logic [4:0] OFS_HALF_BRIDGE_STATUS_CONTROL = 5'h03;
    localparam logic [4:0] OFS_HIGH_SIDE_STATUS_CONTROL = 5'h04;
    localparam logic [4:0] OFS_RESERVED_A = 5'h05;
    localparam logic [4:0] OFS_RESERVED_B = 5'h06;
    localparam logic [4:0] OFS_AUX_OUTPUT_STATUS_CONTROL = 5'h07;
    localparam logic [4:0] OFS_ANALOG_INPUT_MUX_CONTROL = 5'h08;
    localparam logic [4:0] OFS_INTERRUPT_MASK = 5'h09;
    localparam logic [4:0] OFS_INTERRUPT_FLAG = 5'h0A;
    localparam logic [4:0] OFS_WATCHDOG_CONTROL = 5'h0B;
    localparam logic [4:0] OFS_SYSTEM_STATUS = 5'h0C;
    localparam logic [4:0] OFS_RESET_CAUSE_STATUS = 5'h0D;
    localparam logic [4:0] OFS_PRODUCTION_TEST = 5'h0E;
    localparam logic [4:0] OFS_TRIM_ONE = 5'h0F;
    localparam logic [4:0] OFS_TRIM_TWO = 5'h10;
    localparam logic [4:0] OFS_TRIM_THREE = 5'h11;
    localparam logic [7:0] SYSTEM_CONTROL_READ_MASK = 8'h9F;
    localparam logic [7:0] WATCHDOG_CONTROL_READ_MASK = 8'hE0;
    localparam logic [7:0] TRIM_ONE_READ_MASK = 8'hC0;
    localparam int unsigned WD_ENABLE_BIT = 7;
    localparam int unsigned WD_CLEAR_BIT = 0;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_FRAME = 2'b10
    } link_state_t;

    typedef struct packed {
        logic ss_n;
        logic sck;
        logic mosi;
    } spi_pins_t;

    typedef struct packed {
        logic rw;
        logic [4:0] register_select_field;
        logic parity;
        logic spare;
    } cmd_byte_t;

    typedef struct packed {
        logic valid;
        logic [4:0] sel;
        logic [7:0] data;
    } wr_req_t;

    typedef struct packed {
        link_state_t st;
        logic ss_q;
        logic sck_q;
        logic [4:0] cnt;
        logic [4:0] rcnt;
        logic [15:0] rx;
        logic [7:0] stat;
        logic [7:0] hold;
        logic miso;
        logic oe;
        wr_req_t wr;
    } link_reg_t;

    typedef struct packed {
        logic [REG_COUNT-1:0][7:0] regs;
        logic wd_clear;
    } bank_reg_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_reg_t;
endpackage : spi_port_pkg

// ---- pin_sync.sv ----
// Purpose: three stage input synchroniser with agreement filter
// Assumes: pin is asynchronous to ref_clk
// Notes: level follows only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // pin and filtered level
    input wire logic pin,
    output logic level,
    input wire logic init
);
    import spi_port_pkg::*;

    sync_reg_t s;
    sync_reg_t next_s;

    always_comb begin
        next_s = s;
        next_s.s1 = pin;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        if (s.s2 == s.s3) begin
            next_s.level = s.s3;
        end
    end

    // reset value must be constant: init is masked off by the AND with 1'b0 and never reaches level
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // agreement taken straight from the stages: a registered level costs a cycle,
    // and a returned bit would then miss the master's next falling clock
    assign level = ((s.s2 == s.s3) ? s.s3 : s.level) | (init & 1'b0);
endmodule : pin_sync
`default_nettype wire

// ---- reg_bank.sv ----
// Purpose: register storage of the analog die behind the serial port
// Assumes: writes arrive as a one-cycle request after a valid frame
// Notes: field semantics of the stored bytes live elsewhere in the die
`timescale 1ns/1ps
`default_nettype none
module reg_bank (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // write and read from the link
    input wire spi_port_pkg::wr_req_t wr,
    input wire logic [4:0] rd_sel,
    output logic [7:0] rd_data,
    // die side
    input wire logic [7:0] system_status_register,
    output logic [spi_port_pkg::IMAGE_W-1:0] reg_image,
    output logic watchdog_clear_request
);
    import spi_port_pkg::*;

    bank_reg_t s;
    bank_reg_t next_s;

    always_comb begin
        next_s = s;
        next_s.wd_clear = 1'b0;
        if (wr.valid) begin
            unique case (wr.sel)
                OFS_WATCHDOG_CONTROL: begin
                    // enable is set-only; clear bit is not stored
                    next_s.regs[OFS_WATCHDOG_CONTROL][WD_ENABLE_BIT] =
                        s.regs[OFS_WATCHDOG_CONTROL][WD_ENABLE_BIT] | wr.data[WD_ENABLE_BIT];
                    next_s.regs[OFS_WATCHDOG_CONTROL][6:5] = wr.data[6:5];
                    next_s.wd_clear = wr.data[WD_CLEAR_BIT];
                end
                OFS_RESERVED_A, OFS_RESERVED_B, OFS_SYSTEM_STATUS, OFS_PRODUCTION_TEST: begin
                end
                default: begin
                    if (wr.sel < FRAME_BITS + 5'h02) begin
                        next_s.regs[wr.sel] = wr.data;
                    end
                end
            endcase
        end
    end

    always_comb begin
        unique case (rd_sel)
            OFS_SYSTEM_STATUS: rd_data = system_status_register;
            OFS_SYSTEM_CONTROL: rd_data = s.regs[OFS_SYSTEM_CONTROL] & SYSTEM_CONTROL_READ_MASK;
            OFS_WATCHDOG_CONTROL: rd_data = s.regs[OFS_WATCHDOG_CONTROL] & WATCHDOG_CONTROL_READ_MASK;
            OFS_TRIM_ONE: rd_data = s.regs[OFS_TRIM_ONE] & TRIM_ONE_READ_MASK;
            OFS_TRIM_TWO, OFS_TRIM_THREE, OFS_RESERVED_A, OFS_RESERVED_B,
            OFS_PRODUCTION_TEST: rd_data = RESET_BYTE;
            default: rd_data = (rd_sel < FRAME_BITS + 5'h02) ? s.regs[rd_sel] : RESET_BYTE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign reg_image = s.regs;
    assign watchdog_clear_request = s.wd_clear;
endmodule : reg_bank
`default_nettype wire

// ---- spi_register_port.sv ----
// Purpose: serial slave port giving the controller access to die registers
// Assumes: pins sampled by ref_clk; serial clock at most ref_clk / 8
// Notes: edges are found on filtered levels, so each bit lags its pin by ~3 cycles
`timescale 1ns/1ps
`default_nettype none
module spi_register_port (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // serial pins
    input wire spi_port_pkg::spi_pins_t pins,
    output logic miso,
    output logic miso_oe,
    // die side
    input wire logic [7:0] system_status_register,
    output logic [spi_port_pkg::IMAGE_W-1:0] reg_image,
    output logic watchdog_clear_request
);
    import spi_port_pkg::*;

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic ss_l;
    logic sck_l;
    logic mosi_l;

    pin_sync u_sync_ss (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(pins.ss_n),
        .level(ss_l),
        .init(1'b1)
    );

    pin_sync u_sync_sck (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(pins.sck),
        .level(sck_l),
        .init(1'b0)
    );

    pin_sync u_sync_mosi (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(pins.mosi),
        .level(mosi_l),
        .init(1'b0)
    );

    // ************************************************************
    // edge detection
    // ************************************************************
    link_reg_t s;
    link_reg_t next_s;
    logic ss_fall;
    logic ss_rise;
    logic sck_rise;
    logic sck_fall;
    logic in_frame;
    cmd_byte_t cmd;
    logic parity_ok;
    logic [4:0] rd_sel;
    logic [7:0] rd_data;

    // select level after reset is low until filtered; ss_q starts low too, so no false fall edge (the later rise is ignored in idle)
    assign ss_fall = s.ss_q & ~ss_l;
    assign ss_rise = ~s.ss_q & ss_l;
    assign sck_rise = ~s.sck_q & sck_l;
    assign sck_fall = s.sck_q & ~sck_l;
    assign in_frame = (s.st == ST_FRAME);

    // command byte layout, first bit received is the flag
    assign cmd = s.rx[15:8];
    // even ones over flag, address and parity
    assign parity_ok = ~^{cmd.rw, cmd.register_select_field, cmd.parity};
    // address bits already received when parity arrives
    assign rd_sel = s.rx[4:0];

    // ************************************************************
    // register storage
    // ************************************************************
    reg_bank u_bank (
        .ref_clk(ref_clk),
        .rst(rst),
        .wr(s.wr),
        .rd_sel(rd_sel),
        .rd_data(rd_data),
        .system_status_register(system_status_register),
        .reg_image(reg_image),
        .watchdog_clear_request(watchdog_clear_request)
    );

    // ************************************************************
    // frame engine
    // ************************************************************
    always_comb begin
        next_s = s;
        next_s.ss_q = ss_l;
        next_s.sck_q = sck_l;
        next_s.wr = '0;
        unique case (s.st)
            ST_IDLE: begin
                next_s.oe = 1'b0;
                next_s.miso = 1'b0;
                if (ss_fall) begin
                    next_s.st = ST_FRAME;
                    next_s.oe = 1'b1;
                    next_s.cnt = '0;
                    next_s.rcnt = '0;
                    next_s.stat = system_status_register;
                end
            end
            ST_FRAME: begin
                if (ss_rise) begin
                    next_s.st = ST_IDLE;
                    next_s.oe = 1'b0;
                    next_s.miso = 1'b0;
                    // exact sample count; reads never write; bad parity drops it
                    if (s.cnt == FRAME_BITS && !cmd.rw && parity_ok) begin
                        // write at select rise; spare bit unused
                        next_s.wr.valid = 1'b1;
                        next_s.wr.sel = cmd.register_select_field;
                        next_s.wr.data = s.rx[7:0];
                    end
                end else begin
                    if (sck_rise && s.rcnt < FRAME_BITS) begin
                        // shift out on rise; status then data
                        if (s.rcnt < BYTE_BITS) begin
                            next_s.miso = s.stat[3'(5'h07 - s.rcnt)];
                        end else begin
                            // old register contents in second byte
                            next_s.miso = s.hold[3'(5'h0F - s.rcnt)];
                        end
                        next_s.rcnt = s.rcnt + 5'h01;
                    end
                    if (sck_fall) begin
                        next_s.rx = {s.rx[14:0], mosi_l};
                        next_s.cnt = (s.cnt == CNT_OVER) ? CNT_OVER : s.cnt + 5'h01;
                        if (s.cnt == PARITY_SAMPLE) begin
                            next_s.hold = rd_data;
                        end
                    end
                end
            end
            default: begin
                next_s.st = ST_IDLE;
                next_s.oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s <= '{st: ST_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign miso = s.miso;
    assign miso_oe = s.oe;

    // ************************************************************
    // checks
    // ************************************************************
    idle_release_a: assert property (@(posedge ref_clk) disable iff (rst)
        (s.st == ST_IDLE && $past(s.st) == ST_IDLE) |-> !miso_oe)
        else $error("output driven outside a frame");

    frame_start_a: assert property (@(posedge ref_clk) disable iff (rst)
        (s.st == ST_IDLE && ss_fall) |=> (in_frame && miso_oe))
        else $error("frame not opened after select fall");

    frame_drive_a: assert property (@(posedge ref_clk) disable iff (rst)
        in_frame |-> miso_oe)
        else $error("output not driven inside a frame");

    status_snap_a: assert property (@(posedge ref_clk) disable iff (rst)
        (s.st == ST_IDLE && ss_fall) |=> s.stat == $past(system_status_register))
        else $error("status byte not taken at frame start");

    first_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
        (in_frame && !ss_rise && sck_rise && s.rcnt == 5'h00) |=> miso == s.stat[7])
        else $error("first bit is not status msb");

    rise_only_a: assert property (@(posedge ref_clk) disable iff (rst)
        (in_frame && $past(in_frame) && $changed(miso)) |-> $past(sck_rise))
        else $error("output changed away from a clock rise");

    fall_sample_a: assert property (@(posedge ref_clk) disable iff (rst)
        (in_frame && $past(in_frame) && $changed(s.cnt)) |-> $past(sck_fall))
        else $error("sample taken away from a clock fall");

    exact_count_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.wr.valid |-> ($past(s.cnt) == FRAME_BITS && $past(ss_rise)))
        else $error("write from a frame without sixteen samples");

    read_nowrite_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.wr.valid |-> !$past(s.rx[15]))
        else $error("read frame produced a write");

    parity_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.wr.valid |-> $past(parity_ok))
        else $error("write with bad parity accepted");

    hold_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
        (in_frame && !ss_rise && sck_fall && s.cnt == PARITY_SAMPLE) |=> s.hold == $past(rd_data))
        else $error("register not captured at parity bit");

    data_byte_a: assert property (@(posedge ref_clk) disable iff (rst)
        (in_frame && !ss_rise && sck_rise && s.rcnt == BYTE_BITS) |=> miso == s.hold[7])
        else $error("second byte does not start with captured msb");

    wd_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
        watchdog_clear_request |-> ($past(s.wr.valid) && $past(s.wr.sel) == OFS_WATCHDOG_CONTROL))
        else $error("watchdog clear outside a watchdog write");

    wd_single_a: assert property (@(posedge ref_clk) disable iff (rst)
        watchdog_clear_request |=> !watchdog_clear_request)
        else $error("watchdog clear longer than one cycle");

    idle_low_a: assert property (@(posedge ref_clk) disable iff (rst)
        !miso_oe |-> !miso)
        else $error("output data not parked while released");

    image_write_a: assert property (@(posedge ref_clk) disable iff (rst)
        $changed(reg_image) |-> $past(s.wr.valid))
        else $error("register changed without a finished write frame");

    write_take_a: assert property (@(posedge ref_clk) disable iff (rst)
        (in_frame && ss_rise && s.cnt == FRAME_BITS && !cmd.rw && parity_ok) |=> s.wr.valid)
        else $error("valid write frame dropped");

    write_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
        s.wr.valid |-> s.wr.sel == $past(s.rx[14:10]))
        else $error("write aimed at the wrong register");

    write_data_a: assert property (@(posedge ref_clk) disable iff (rst)
        (s.wr.valid && s.wr.sel == OFS_HALF_BRIDGE_OUTPUT) |=> reg_image[15:8] == $past(s.wr.data))
        else $error("write data not stored");

    cover_write_c: cover property (@(posedge ref_clk) disable iff (rst) s.wr.valid);
    cover_read_c: cover property (@(posedge ref_clk) disable iff (rst)
        (in_frame && ss_rise && s.cnt == FRAME_BITS && cmd.rw));
    cover_short_c: cover property (@(posedge ref_clk) disable iff (rst)
        (in_frame && ss_rise && s.cnt != FRAME_BITS));
    cover_parity_c: cover property (@(posedge ref_clk) disable iff (rst)
        (in_frame && ss_rise && s.cnt == FRAME_BITS && !cmd.rw && !parity_ok));
endmodule : spi_register_port
`default_nettype wire

// ---- spi_port_pkg_unused_guard.sv ----
`default_nettype none
`default_nettype wire

// ---- spi_master_model.sv ----
// Purpose: serial master model standing for the on-package controller
// Assumes: link clock period 800 ns, idle low, started just after a ref_clk rise
// Notes: between frames select, clock and data rest at their pull levels
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    // serial pins
    output var spi_port_pkg::spi_pins_t pins,
    input wire logic miso_line
);
    import spi_port_pkg::*;
    localparam time HALF = 400ns;

    initial begin
        pins.ss_n = 1'h1;
        pins.sck = 1'h0;
        pins.mosi = 1'h0;
    end

    // ****************************************
    // frame driver
    // ****************************************
    // nbits bits of the two bytes, msb first, under select
    task automatic xfer(input logic [15:0] tx, input int nbits, input bit keep, output logic [15:0] rx);
        rx = 16'h0000;
        pins.ss_n = 1'h0;
        #HALF;
        for (int i = 0; i < nbits; i++) begin
            pins.sck = 1'h1;
            pins.mosi = tx[15 - (i % 16)];
            #HALF;
            pins.sck = 1'h0;
            rx = {rx[14:0], miso_line};
            #HALF;
        end
        if (!keep) begin
            end_frame();
        end
    endtask : xfer

    // released data falls to its pull-down; gap lets the write land
    task automatic end_frame();
        pins.ss_n = 1'h1;
        pins.mosi = 1'h0;
        #1000ns;
    endtask : end_frame
endmodule : spi_master_model
`default_nettype wire

// ---- analog_die_spi_register_port_tb.sv ----
// Purpose: self-checking bench of the serial register port
// Assumes: master model drives pins, bench keeps an expected register image
// Notes: expected read values use the documented read masks
`timescale 1ns/1ps
`default_nettype none
module analog_die_spi_register_port_tb;
    import spi_port_pkg::*;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    spi_pins_t pins;
    logic miso;
    logic miso_oe;
    wire logic miso_line;
    logic [7:0] stat_in = 8'hA6;
    logic [IMAGE_W-1:0] reg_image;
    logic wd_clear;
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    int wd_count = 0;
    logic [7:0] shadow [0:17];

    // no pull on the returned data line
    assign miso_line = miso_oe ? miso : 1'hZ;

    spi_register_port spi_register_port_inst (.ref_clk(ref_clk), .rst(rst), .pins(pins), .miso(miso),
        .miso_oe(miso_oe), .system_status_register(stat_in), .reg_image(reg_image),
        .watchdog_clear_request(wd_clear));
    spi_master_model spi_master_model_inst (.pins(pins), .miso_line(miso_line));

    always #50ns ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles++;
        if (wd_clear === 1'h1) begin
            wd_count++;
        end
        if (cycles == 30000) begin
            err_total++;
            close_out();
        end
    end

    // ****************************************
    // helpers
    // ****************************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    function automatic logic [7:0] rmask(input logic [4:0] a);
        case (a)
            5'h00: return 8'h9F;
            5'h0B: return 8'hE0;
            5'h0F: return 8'hC0;
            5'h05, 5'h06, 5'h0E, 5'h10, 5'h11: return 8'h00;
            default: return 8'hFF;
        endcase
    endfunction : rmask

    function automatic logic [7:0] exp_of(input logic [4:0] a);
        return (a == 5'h0C) ? stat_in : shadow[a];
    endfunction : exp_of

    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic x, input logic bad,
                      input int nbits, input bit keep);
        logic [15:0] rx;
        int wd0;
        logic ok;
        logic [7:0] img0;
        ok = !bad && nbits == 16 && !(a inside {5'h05, 5'h06, 5'h0C, 5'h0E}) && a <= 5'h11;
        wd0 = wd_count;
        img0 = reg_image[8*a +: 8];
        spi_master_model_inst.xfer({1'h0, a, (^a) ^ bad, x, d}, nbits, keep, rx);
        if (nbits == 16 && a <= 5'h11) begin
            chk8("status_byte", stat_in, rx[15:8]);
            chk8("old_data", exp_of(a), rx[7:0]);
        end
        if (keep) begin
            repeat (10) @(posedge ref_clk);
            #1;
            chk8("held_image", img0, reg_image[8*a +: 8]);
            chk8("held_clear", 8'h00, 8'(wd_count - wd0));
            spi_master_model_inst.end_frame();
        end
        if (ok) begin
            shadow[a] = (a == 5'h0B) ? {shadow[a][7] | d[7], d[6:5], 5'h00} : d & rmask(a);
        end
        chk8("clear_pulses", {7'h00, ok && a == 5'h0B && d[0]}, 8'(wd_count - wd0));
        chk8("idle_enable", 8'h00, {7'h00, miso_oe});
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic bad);
        logic [15:0] rx;
        spi_master_model_inst.xfer({1'h1, a, (~^a) ^ bad, 1'h0, 8'h96}, 16, 1'b0, rx);
        chk8("status_byte", stat_in, rx[15:8]);
        chk8("read_data", exp_of(a), rx[7:0]);
    endtask : rd

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        for (int a = 0; a < 18; a++) begin
            shadow[a] = 8'h00;
        end
        repeat (4) @(posedge ref_clk);
        #1;
        rst = 1'h0;
        chk8("reset_enable", 8'h00, {7'h00, miso_oe});
        chk8("reset_image", 8'h00, {7'h00, |reg_image});
        chk8("reset_clear", 8'h00, {7'h00, wd_clear});
        repeat (6) @(posedge ref_clk);
        #1;
        for (int p = 0; p < 2; p++) begin
            for (int a = 0; a < 18; a++) begin
                stat_in = 8'hA6 ^ 8'(a << 3);
                wr(5'(a), 8'hC3 ^ 8'(a * 8'h1D) ^ {8{p[0]}}, 1'h0, 1'h0, 16, 1'b0);
                rd(5'(a), 1'h0);
            end
        end
        wr(5'h13, 8'h77, 1'h0, 1'h0, 16, 1'b0);
        wr(5'h01, 8'h3C, 1'h0, 1'h1, 16, 1'b0);
        rd(5'h01, 1'h0);
        rd(5'h02, 1'h1);
        wr(5'h02, 8'h81, 1'h1, 1'h0, 16, 1'b0);
        rd(5'h02, 1'h0);
        wr(5'h01, 8'h42, 1'h0, 1'h0, 15, 1'b0);
        rd(5'h01, 1'h0);
        wr(5'h01, 8'h42, 1'h0, 1'h0, 17, 1'b0);
        rd(5'h01, 1'h0);
        wr(5'h01, 8'h5B, 1'h0, 1'h0, 16, 1'b1);
        rd(5'h01, 1'h0);
        wr(5'h0B, 8'h61, 1'h0, 1'h0, 16, 1'b1);
        rd(5'h0B, 1'h0);
        close_out();
    end
endmodule : analog_die_spi_register_port_tb
`default_nettype wire
